// >>> include/dpw_pkg.sv
`default_nettype none
package dpw_pkg;
  // ============================================================
  // Code width and presets
  localparam int          CODE_W      = 6;
  localparam logic [5:0]  CODE_HALF   = 6'h20;
  localparam logic [5:0]  CODE_FULL   = 6'h3f;
  localparam logic [5:0]  CODE_ZERO   = 6'h00;
  // Cycles after reset release before the one mode decision
  localparam logic [1:0]  MODE_SETTLE = 2'h3;
  // ============================================================
  // Timing, clk at 10 MHz
  localparam longint CLK_HZ          = 10000000;
  localparam longint DEBOUNCE_US     = 12800;
  localparam longint REPEAT_DELAY_MS = 410;
  localparam longint REPEAT_MHZ      = 19500;
  localparam longint PWM_MIN_HZ      = 3000;
  localparam longint DEBOUNCE_CYC    = (CLK_HZ * DEBOUNCE_US + 999999) / 1000000;
  localparam longint DELAY_CYC       = (CLK_HZ * REPEAT_DELAY_MS + 999) / 1000;
  localparam longint REPEAT_CYC      = (CLK_HZ * 1000) / REPEAT_MHZ;
  // PWM slot length in clk cycles; 64 slots give period below 1/3 kHz
  localparam longint PWM_SLOT_CYC    = CLK_HZ / (PWM_MIN_HZ * 64);
  // ============================================================
  // Pin sense states
  typedef enum logic [2:0]
  {
    PIN_LOW  = 3'b001,
    PIN_HIGH = 3'b010,
    PIN_MID  = 3'b100
  } dpw_pin_type;
endpackage : dpw_pkg
`default_nettype wire

// >>> rtl/dpw_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_channel
#(
  parameter int DEB_CYC = 128000,
  parameter int DLY_CYC = 4100000,
  parameter int REP_CYC = 512
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        pulse_mode,
  input  wire logic        pin_hi,
  input  wire logic        pin_lo,
  output logic [5:0]       code
);
  initial
  begin
    if (DEB_CYC < 1 || DLY_CYC < 1 || REP_CYC < 1)
      $error("dpw_channel: counts must be at least one");
  end
  // ============================================================
  // Debounce and repeat state
  logic        hi_prev_reg;
  logic [1:0]  press_reg;
  logic [1:0]  raw;
  logic [31:0] deb_reg;
  logic [31:0] rep_reg;
  logic        held_reg;
  logic        first_reg;
  logic        step_up;
  logic        step_dn;
  logic        tick;

  assign raw = pulse_mode ? 2'b00 : {pin_hi, pin_lo};
  // Repeat timer expiry also fires the first step once debounce completes
  assign tick    = held_reg && (rep_reg == 32'h0);
  assign step_up = run && !pulse_mode && tick && press_reg[1];
  assign step_dn = run && !pulse_mode && tick && press_reg[0];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      press_reg <= 2'b00;
      deb_reg   <= 32'h0;
      held_reg  <= 1'b0;
    end
    else if (run)
    begin
      if (raw != press_reg || raw == 2'b00)
      begin
        press_reg <= raw;
        deb_reg   <= 32'h0;
        held_reg  <= 1'b0;
      end
      else if (!held_reg)
      begin
        if (deb_reg >= 32'(DEB_CYC - 1))
          held_reg <= 1'b1;
        else
          deb_reg <= deb_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rep_reg   <= 32'h0;
      first_reg <= 1'b1;
    end
    else if (run)
    begin
      if (!held_reg)
      begin
        rep_reg   <= 32'h0;
        first_reg <= 1'b1;
      end
      else if (tick)
      begin
        rep_reg   <= first_reg ? 32'(DLY_CYC - 1) : 32'(REP_CYC - 1);
        first_reg <= 1'b0;
      end
      else
        rep_reg <= rep_reg - 32'h1;
    end
  end

  // Edge memory follows the pin even while idle, so a level held since
  // power-up or through shutdown never counts as a fresh edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hi_prev_reg <= 1'b0;
    else
      hi_prev_reg <= pin_hi;
  end

  // ============================================================
  // Code counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      code <= dpw_pkg::CODE_HALF;
    else if (run)
    begin
      if (pulse_mode && pin_hi && !hi_prev_reg)
        code <= code + 6'h01;
      else if (step_up && code != dpw_pkg::CODE_FULL)
        code <= code + 6'h01;
      else if (step_dn && code != dpw_pkg::CODE_ZERO)
        code <= code - 6'h01;
    end
  end
endmodule : dpw_channel
`default_nettype wire

// >>> rtl/dpw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Any driven count pin at power-up selects pulse mode until power-on reset.
// - Both pins floating: keep sense network, resolve high, low, middle per pin.
// - Any pin driven at power-up: disconnect sense network, plain logic inputs.
// - Both channels share one mode; mixed float and driven gives pulse mode.
// - Each pulse-mode rising edge increments only that channel by one.
// - Pulse-mode increment from full scale wraps to zero.
// - Pushbutton high press increments, saturating at full scale.
// - Pushbutton low press decrements, saturating at zero.
// - Pushbutton inputs debounced 12.8 ms before a press counts.
// - Held press repeats after 410 ms at 19.5 Hz until release.
// - Low shutdown input stops all normal activity.
// - Codes kept through shutdown and resumed on release.
// - Power-up presets both counters to half scale.
// - Both PWM outputs high impedance while shut down.
// - PWM duty is code over 64, sixty-four equal steps.
// - PWM repetition frequency stays above 3 kHz.
module dpw_ctrl
#(
  parameter int DEB_CYC  = int'(dpw_pkg::DEBOUNCE_CYC),
  parameter int DLY_CYC  = int'(dpw_pkg::DELAY_CYC),
  parameter int REP_CYC  = int'(dpw_pkg::REPEAT_CYC),
  parameter int SLOT_CYC = int'(dpw_pkg::PWM_SLOT_CYC)
)
(
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  shutdown_n,
  input  wire logic  chan1_count_input,
  input  wire logic  chan2_count_input,
  input  wire logic  chan1_sense_up,
  input  wire logic  chan1_sense_dn,
  input  wire logic  chan2_sense_up,
  input  wire logic  chan2_sense_dn,
  output logic       sense_connect,
  output logic       pulse_mode,
  output logic       chan1_pwm_output,
  output logic       chan1_pwm_oe_n,
  output logic       chan2_pwm_output,
  output logic       chan2_pwm_oe_n,
  output logic [5:0] chan1_code,
  output logic [5:0] chan2_code
);
  initial
  begin
    if (SLOT_CYC < 1)
      $error("dpw_ctrl: SLOT_CYC must be at least one");
    // Slot counter is sixteen bits wide
    if (SLOT_CYC > 65536)
      $error("dpw_ctrl: SLOT_CYC must fit the slot counter");
  end
  // ============================================================
  // Input synchronisers
  logic [6:0] s1_reg;
  logic [6:0] s2_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
    end
    else
    begin
      s1_reg <= {shutdown_n, chan1_count_input, chan2_count_input, chan1_sense_up,
                 chan1_sense_dn, chan2_sense_up, chan2_sense_dn};
      s2_reg <= s1_reg;
    end
  end
  logic run;
  logic c1;
  logic c2;
  assign run = s2_reg[6];
  assign c1  = s2_reg[5];
  assign c2  = s2_reg[4];

  // Sense pair: up-biased and down-biased reads; disagreement means floating
  function automatic dpw_pkg::dpw_pin_type sense(input logic up, input logic dn);
    if (up && dn)
      sense = dpw_pkg::PIN_HIGH;
    else if (!up && !dn)
      sense = dpw_pkg::PIN_LOW;
    else
      sense = dpw_pkg::PIN_MID;
  endfunction : sense

  dpw_pkg::dpw_pin_type p1;
  dpw_pkg::dpw_pin_type p2;
  assign p1 = sense(s2_reg[3], s2_reg[2]);
  assign p2 = sense(s2_reg[1], s2_reg[0]);

  // ============================================================
  // Mode detect, one decision after reset release
  logic [1:0] wait_reg;
  logic       decided_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_reg      <= 2'h0;
      decided_reg   <= 1'b0;
      pulse_mode    <= 1'b0;
      sense_connect <= 1'b1;
    end
    else if (!decided_reg)
    begin
      // Wait for synchronisers to fill before sampling
      if (wait_reg != dpw_pkg::MODE_SETTLE)
        wait_reg <= wait_reg + 2'h1;
      else
      begin
        decided_reg <= 1'b1;
        if (p1 != dpw_pkg::PIN_MID || p2 != dpw_pkg::PIN_MID)
        begin
          pulse_mode    <= 1'b1;
          sense_connect <= 1'b0;
        end
        else
          sense_connect <= 1'b1;
      end
    end
  end

  logic go;
  assign go = run && decided_reg;

  // Pulse mode reads the plain pin; pushbutton mode reads the sense pair
  logic hi1;
  logic lo1;
  logic hi2;
  logic lo2;
  assign hi1 = pulse_mode ? c1 : (p1 == dpw_pkg::PIN_HIGH);
  assign lo1 = !pulse_mode && (p1 == dpw_pkg::PIN_LOW);
  assign hi2 = pulse_mode ? c2 : (p2 == dpw_pkg::PIN_HIGH);
  assign lo2 = !pulse_mode && (p2 == dpw_pkg::PIN_LOW);

  // ============================================================
  // Channels; in pushbutton mode high and low come from three-state sense
  dpw_channel
  #(
    .DEB_CYC (DEB_CYC),
    .DLY_CYC (DLY_CYC),
    .REP_CYC (REP_CYC)
  )
  u_ch1
  (
    .clk        (clk),
    .resetn     (resetn),
    .run        (go),
    .pulse_mode (pulse_mode),
    .pin_hi     (hi1),
    .pin_lo     (lo1),
    .code       (chan1_code)
  );

  dpw_channel
  #(
    .DEB_CYC (DEB_CYC),
    .DLY_CYC (DLY_CYC),
    .REP_CYC (REP_CYC)
  )
  u_ch2
  (
    .clk        (clk),
    .resetn     (resetn),
    .run        (go),
    .pulse_mode (pulse_mode),
    .pin_hi     (hi2),
    .pin_lo     (lo2),
    .code       (chan2_code)
  );

  // ============================================================
  // PWM timebase
  logic [15:0] slot_reg;
  logic [5:0]  phase_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slot_reg  <= 16'h0;
      phase_reg <= 6'h00;
    end
    else if (run)
    begin
      if (slot_reg >= 16'(SLOT_CYC - 1))
      begin
        slot_reg  <= 16'h0;
        phase_reg <= phase_reg + 6'h01;
      end
      else
        slot_reg <= slot_reg + 16'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan1_pwm_output <= 1'b0;
      chan2_pwm_output <= 1'b0;
      chan1_pwm_oe_n   <= 1'b1;
      chan2_pwm_oe_n   <= 1'b1;
    end
    else
    begin
      chan1_pwm_output <= run && (phase_reg < chan1_code);
      chan2_pwm_output <= run && (phase_reg < chan2_code);
      chan1_pwm_oe_n   <= !run;
      chan2_pwm_oe_n   <= !run;
    end
  end
endmodule : dpw_ctrl
`default_nettype wire

// >>> sim/dpw_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pin model: 00 float, 01 low, 11 high
module dpw_pin_model
(
  input  wire logic [1:0] st,
  output logic            pin,
  output logic            up,
  output logic            dn
);
  assign pin = st[1];
  assign up  = st[1] | ~st[0];
  assign dn  = st[1];
endmodule : dpw_pin_model
`default_nettype wire

// >>> sim/dpw_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module dpw_ctrl_checker
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       shutdown_n,
  input wire logic       chan2_count_input,
  input wire logic       sense_connect,
  input wire logic       pulse_mode,
  input wire logic       chan1_pwm_output,
  input wire logic       chan1_pwm_oe_n,
  input wire logic       chan2_pwm_oe_n,
  input wire logic [5:0] chan1_code,
  input wire logic [5:0] chan2_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_mode_sticky: assert property ($past(pulse_mode) |-> pulse_mode)
    else $error("mode left pulse");
  a_link_mode: assert property (pulse_mode |-> !sense_connect)
    else $error("sense kept in pulse mode");
  a_shutdown_n_hiz: assert property ((!shutdown_n)[*4] |-> chan1_pwm_oe_n && chan2_pwm_oe_n)
    else $error("output driven in shutdown");
  a_shutdown_n_hold: assert property ((!shutdown_n)[*5] |-> $stable(chan1_code) && $stable(chan2_code))
    else $error("code moved in shutdown");
  a_pulse_wrap: assert property (pulse_mode && chan1_code != $past(chan1_code)
    |-> chan1_code == $past(chan1_code) + 6'h01)
    else $error("pulse step wrong");
  a_chan_only: assert property ((pulse_mode && !chan2_count_input)[*5] |-> $stable(chan2_code))
    else $error("idle channel moved");
  a_button_top: assert property (!pulse_mode && $past(chan1_code) == 6'h3f |-> chan1_code inside {6'h3f, 6'h3e})
    else $error("button wrapped at top");
  a_button_floor: assert property (!pulse_mode && $past(chan1_code) == 6'h00 |-> chan1_code inside {6'h00, 6'h01})
    else $error("button wrapped at zero");
  a_zero_low: assert property ((!chan1_pwm_oe_n && chan1_code == 6'h00)[*3] |-> !chan1_pwm_output)
    else $error("pwm high at code zero");
endmodule : dpw_ctrl_checker
bind dpw_ctrl dpw_ctrl_checker dpw_ctrl_checker_i (.clk, .resetn, .shutdown_n, .chan2_count_input,
  .sense_connect, .pulse_mode, .chan1_pwm_output, .chan1_pwm_oe_n, .chan2_pwm_oe_n, .chan1_code,
  .chan2_code);
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEB = 4;
  localparam int DLY = 20;
  localparam int REP = 5;
  logic       clk             = 1'b0;
  logic       resetn          = 1'b0;
  logic       shutdown_n      = 1'b1;
  logic [1:0] st [1:2]        = '{2'b00, 2'b00};
  logic       c1, c2, u1, d1, u2, d2, sc, pm, p1, o1, p2, o2;
  logic [5:0] code1, code2;
  int         num_errors      = 0;
  int         samples_checked = 0;
  int         n;
  always #50 clk = ~clk;
  dpw_pin_model dpw_pin_model_i (.st(st[1]), .pin(c1), .up(u1), .dn(d1));
  dpw_pin_model dpw_pin_model_j (.st(st[2]), .pin(c2), .up(u2), .dn(d2));
  // Short counts keep the run small
  dpw_ctrl #(.DEB_CYC(DEB), .DLY_CYC(DLY), .REP_CYC(REP), .SLOT_CYC(1)) dpw_ctrl_i
  (.clk(clk), .resetn(resetn), .shutdown_n(shutdown_n), .chan1_count_input(c1),
   .chan2_count_input(c2), .chan1_sense_up(u1), .chan1_sense_dn(d1), .chan2_sense_up(u2),
   .chan2_sense_dn(d2), .sense_connect(sc), .pulse_mode(pm), .chan1_pwm_output(p1),
   .chan1_pwm_oe_n(o1), .chan2_pwm_output(p2), .chan2_pwm_oe_n(o2), .chan1_code(code1),
   .chan2_code(code2));
  // ==========
  // Helpers
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic check(string nm, logic [5:0] e, logic [5:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wait_code(logic [5:0] e, int lim);
    n = 0;
    while (code1 !== e && n < lim)
    begin
      tick(1);
      n++;
    end
    check("wait_code1", e, code1);
    if (code1 !== e)
      close_out();
  endtask : wait_code
  task automatic power_up(logic [1:0] s1, logic [1:0] s2, logic mode);
    st[1] = s1;
    st[2] = s2;
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(8);
    check("pulse_mode", {5'h00, mode}, {5'h00, pm});
    check("sense_connect", {5'h00, !mode}, {5'h00, sc});
    check("code1", 6'h20, code1);
    check("code2", 6'h20, code2);
  endtask : power_up
  // Far side keeps high and low at least three cycles each
  task automatic pulse(int ch, int k);
    repeat (k)
    begin
      st[ch] = 2'b11;
      tick(3);
      st[ch] = 2'b01;
      tick(3);
    end
  endtask : pulse
  task automatic duty(logic [5:0] e1, logic [5:0] e2);
    int h1 = 0;
    int h2 = 0;
    repeat (64)
    begin
      tick(1);
      if (p1 === 1'b1)
        h1++;
      if (p2 === 1'b1)
        h2++;
    end
    check("duty1", e1, h1[5:0]);
    check("duty2", e2, h2[5:0]);
  endtask : duty
  // ==========
  // Scenarios
  task automatic pulse_scn();
    power_up(2'b00, 2'b11, 1'b1);
    st[2] = 2'b01;
    pulse(1, 1);
    check("code1", 6'h21, code1);
    check("code2", 6'h20, code2);
    duty(6'h21, 6'h20);
    pulse(1, 31);
    check("code1", 6'h00, code1);
    duty(6'h00, 6'h20);
    pulse(2, 63);
    check("code2", 6'h1f, code2);
    duty(6'h00, 6'h1f);
  endtask : pulse_scn
  task automatic shutdown_n_scn();
    shutdown_n = 1'b0;
    tick(4);
    pulse(1, 2);
    check("code1", 6'h00, code1);
    check("oe1", 6'h01, {5'h00, o1});
    check("oe2", 6'h01, {5'h00, o2});
    check("chan2_pwm_output", 6'h00, {5'h00, p2});
    shutdown_n = 1'b1;
    tick(4);
    check("code1", 6'h00, code1);
    check("code2", 6'h1f, code2);
    check("oe1", 6'h00, {5'h00, o1});
    check("oe2", 6'h00, {5'h00, o2});
    pulse(1, 1);
    check("code1", 6'h01, code1);
  endtask : shutdown_n_scn
  task automatic button_scn();
    power_up(2'b00, 2'b00, 1'b0);
    st[1] = 2'b11;
    tick(DEB - 2);
    st[1] = 2'b00;
    tick(10);
    check("code1", 6'h20, code1);
    st[1] = 2'b11;
    wait_code(6'h21, DEB + 10);
    check("deb_ok", 6'h01, 6'(n >= DEB && n <= DEB + 5));
    wait_code(6'h22, DLY + 10);
    check("delay_ok", 6'h01, 6'(n >= DLY - 2 && n <= DLY + 2));
    wait_code(6'h23, REP + 5);
    check("rep_ok", 6'h01, 6'(n >= REP - 1 && n <= REP + 1));
    tick(300);
    check("code1", 6'h3f, code1);
    st[1] = 2'b01;
    tick(450);
    check("code1", 6'h00, code1);
    check("code2", 6'h20, code2);
    st[1] = 2'b00;
  endtask : button_scn
  initial
  begin
    pulse_scn();
    shutdown_n_scn();
    button_scn();
    close_out();
  end
endmodule : testbench
`default_nettype wire
